// File: hdl/pse_port_device.sv
// port mode sequencer of the power-sourcing device
//
// What this block does
// - decode mode field, auto needs strap high
// - mode 00b keeps port fully shut down
// - manual: one commanded cycle, report, idle
// - manual honours power on/off commands anytime
// - semi-auto repeats detect/class, reports each
// - semi-auto powers only on host command
// - semi/auto: no detection until host enables it; manual detects on command
// - auto mode powers on after good detection
// - thresholds self-assigned only in auto mode
// - strap must be high when reset releases for auto mode
// - current-limit fault always removes power
// - enabled disconnect removes power, any mode
// - host power-off honoured at any time
// - extended class needs high-power and extended enable
// - strapped: refuse classes above variant limit
// - type 1 variant: class 4 as 0
// - type 1 variant meant for strapped use
// - unclassified device budgeted at 13W
// - semi-auto waits 100ms, 2s for midspan
// - semi-auto high power: power-on needs good detect
// - strap and midspan latched only at reset
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module pse_port_device
    import pse_mode_pkg::*;
#(
    parameter int unsigned WAIT_CYC     = pse_mode_pkg::WAIT_CYC_DEF,
    parameter int unsigned WAIT_MID_CYC = pse_mode_pkg::WAIT_MID_CYC_DEF,
    parameter int unsigned VARIANT_MW   = pse_mode_pkg::VARIANT_MW_DEF,
    parameter bit          TYPE1_ONLY   = 1'b0
)(
    input  wire logic        clk,
    input  wire logic        nrst,
    pse_link_if.device       link,
    input  wire logic        strap_auto,
    input  wire logic        strap_mid,
    input  wire logic        detect_done,
    input  wire logic [2:0]  detect_code,
    input  wire logic        class_done,
    input  wire logic [3:0]  class_code,
    input  wire logic        ilim_fault,
    input  wire logic        disconnect,
    output logic             detect_start,
    output logic             class_start,
    output logic             class_ext,
    output logic             gate_on,
    output logic [3:0]       icut_sel,
    output logic             ilim_high,
    output logic [16:0]      budget_mw
);
    import pse_mode_pkg::*;

    port_state_t state;
    mode_t       mode;
    logic        auto_latched;
    logic        mid_latched;
    logic        straps_taken;
    logic [31:0] wait_cnt;
    logic        classified;
    logic        auto_on_req;
    logic        kill;
    logic        over_limit;
    logic        want_on;
    logic        refuse_hp;
    logic [3:0]  next_cls;
    logic        port_off_mode;

    // straps are caught once after release, never while reset is low
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            auto_latched <= 1'b0;
            mid_latched  <= 1'b0;
            straps_taken <= 1'b0;
        end
        else if (!straps_taken)
        begin
            auto_latched <= strap_auto;
            mid_latched  <= strap_mid;
            straps_taken <= 1'b1;
        end
    end

    assign mode = decode_mode(link.port_op_mode_field, auto_latched);
    assign port_off_mode = (mode == MODE_SHUTDOWN) || (mode == MODE_RESERVED);

    assign kill = ilim_fault
               || (disconnect && link.disc_en)
               || link.cmd_off
               || port_off_mode
               || !straps_taken;

    assign over_limit = auto_latched && (32'(class_mw(link.cls_result)) > VARIANT_MW);
    assign refuse_hp  = (mode == MODE_SEMI) && link.hp_en
                     && (link.det_result != DET_GOOD);
    assign want_on    = link.cmd_on && !port_off_mode;
    assign next_cls   = (TYPE1_ONLY && class_code == CLS_4) ? CLS_0 : class_code;

    // sequencer
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state        <= ST_IDLE;
            wait_cnt     <= 32'h0;
            detect_start <= 1'b0;
            class_start  <= 1'b0;
            class_ext    <= 1'b0;
            auto_on_req  <= 1'b0;
            classified   <= 1'b0;
            link.det_result   <= DET_UNKNOWN;
            link.cls_result   <= CLS_0;
            link.status_valid <= 1'b0;
        end
        else
        begin
            detect_start      <= 1'b0;
            class_start       <= 1'b0;
            auto_on_req       <= 1'b0;
            link.status_valid <= 1'b0;
            if (port_off_mode)
                state <= ST_IDLE;
            else if (ilim_fault && gate_on)
                state <= ST_FAULTED;
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        if (gate_on)
                            state <= ST_POWERED;
                        else if (mode == MODE_MANUAL && link.cmd_detect)
                        begin
                            state        <= ST_DETECTING;
                            detect_start <= 1'b1;
                            classified   <= 1'b0;
                        end
                        else if (mode == MODE_MANUAL && link.cmd_class)
                        begin
                            state       <= ST_CLASSIFYING;
                            class_start <= 1'b1;
                            class_ext   <= link.hp_en && link.extended_power_enable_bit
                                        && !TYPE1_ONLY;
                        end
                        else if (mode != MODE_MANUAL && link.detect_en)
                        begin
                            state        <= ST_DETECTING;
                            detect_start <= 1'b1;
                            classified   <= 1'b0;
                        end
                    end
                    ST_DETECTING:
                    begin
                        if (detect_done)
                        begin
                            link.det_result   <= detect_code;
                            link.status_valid <= 1'b1;
                            if (mode == MODE_MANUAL)
                                state <= ST_IDLE;
                            else if (detect_code == DET_GOOD && link.class_en)
                            begin
                                state       <= ST_CLASSIFYING;
                                class_start <= 1'b1;
                                class_ext   <= link.hp_en && link.extended_power_enable_bit
                                            && !TYPE1_ONLY;
                            end
                            else
                            begin
                                state       <= ST_BACKOFF;
                                wait_cnt    <= 32'h0;
                                auto_on_req <= (mode == MODE_AUTO)
                                            && (detect_code == DET_GOOD);
                            end
                        end
                    end
                    ST_CLASSIFYING:
                    begin
                        if (class_done)
                        begin
                            link.cls_result   <= next_cls;
                            link.status_valid <= 1'b1;
                            classified        <= 1'b1;
                            if (mode == MODE_MANUAL)
                                state <= ST_IDLE;
                            else
                            begin
                                state       <= ST_BACKOFF;
                                wait_cnt    <= 32'h0;
                                auto_on_req <= (mode == MODE_AUTO)
                                            && (link.det_result == DET_GOOD);
                            end
                        end
                    end
                    ST_BACKOFF:
                    begin
                        // long wait keeps the status fresh without hammering the cable
                        wait_cnt <= wait_cnt + 32'h1;
                        if (gate_on)
                            state <= ST_POWERED;
                        else if (wait_cnt + 32'h1 >= (mid_latched ? WAIT_MID_CYC : WAIT_CYC))
                            state <= ST_IDLE;
                    end
                    ST_POWERED:
                    begin
                        if (!gate_on)
                            state <= ST_IDLE;
                    end
                    ST_FAULTED:
                        state <= ST_IDLE;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // power switch and its events
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            gate_on            <= 1'b0;
            link.power_on      <= 1'b0;
            link.startup_fault <= 1'b0;
            link.ilim_event    <= 1'b0;
            link.disc_event    <= 1'b0;
        end
        else
        begin
            link.startup_fault <= 1'b0;
            link.ilim_event    <= ilim_fault && gate_on;
            link.disc_event    <= disconnect && link.disc_en && gate_on;
            if (kill)
                gate_on <= 1'b0;
            else if (auto_on_req && !over_limit)
                gate_on <= 1'b1;
            else if (want_on && !gate_on)
            begin
                if (refuse_hp || over_limit)
                    link.startup_fault <= 1'b1;
                else
                    gate_on <= 1'b1;
            end
            link.power_on <= gate_on;
        end
    end

    // thresholds and budget
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            icut_sel        <= CLS_0;
            ilim_high       <= 1'b0;
            budget_mw       <= BASE_MW;
            link.auto_strap <= 1'b0;
        end
        else
        begin
            link.auto_strap <= auto_latched;
            budget_mw <= classified ? class_mw(link.cls_result) : BASE_MW;
            if (mode == MODE_AUTO)
            begin
                icut_sel  <= link.cls_result;
                ilim_high <= (link.cls_result >= CLS_4);
            end
        end
    end
endmodule

// File: hdl/pse_mode_pkg.sv
// shared constants, types and decode helpers for the port mode controller
package pse_mode_pkg;
    localparam logic [1:0] OPM_SHUTDOWN = 2'h0;
    localparam logic [1:0] OPM_MANUAL   = 2'h1;
    localparam logic [1:0] OPM_SEMI     = 2'h2;
    localparam logic [1:0] OPM_AUTO     = 2'h3;

    localparam logic [2:0] DET_UNKNOWN = 3'h0;
    localparam logic [2:0] DET_GOOD    = 3'h4;

    localparam logic [3:0] CLS_0 = 4'h0;
    localparam logic [3:0] CLS_4 = 4'h4;

    localparam logic [16:0] BASE_MW = 17'h032C8;

    localparam longint unsigned CLK_HZ      = 200000000;
    localparam longint unsigned WAIT_MS     = 100;
    localparam longint unsigned WAIT_MID_MS = 2000;
    localparam int unsigned WAIT_CYC_DEF     = 32'(WAIT_MS * (CLK_HZ / 1000));
    localparam int unsigned WAIT_MID_CYC_DEF = 32'(WAIT_MID_MS * (CLK_HZ / 1000));
    localparam int unsigned VARIANT_MW_DEF   = 90000;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CMD    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_BUDGET = 4'hC;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DET_EN   = 2;
    localparam int CTRL_CLS_EN   = 3;
    localparam int CTRL_HP_EN    = 4;
    localparam int CTRL_EXT_EN   = 5;
    localparam int CTRL_DISC_EN  = 6;
    localparam int CMD_DETECT    = 0;
    localparam int CMD_CLASS     = 1;
    localparam int CMD_ON        = 2;
    localparam int CMD_OFF       = 3;
    localparam int ST_DET_LSB    = 0;
    localparam int ST_CLS_LSB    = 4;
    localparam int ST_POWER      = 8;
    localparam int ST_STRAP      = 9;
    localparam int ST_STARTUP    = 12;
    localparam int ST_ILIM       = 13;
    localparam int ST_DISC       = 14;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    typedef enum logic [2:0] {
        MODE_SHUTDOWN, MODE_MANUAL, MODE_SEMI, MODE_AUTO, MODE_RESERVED
    } mode_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DETECTING, ST_CLASSIFYING, ST_BACKOFF, ST_POWERED, ST_FAULTED
    } port_state_t;

    function automatic mode_t decode_mode(input logic [1:0] field, input logic strap);
        if (field == OPM_AUTO)
            decode_mode = strap ? MODE_AUTO : MODE_RESERVED;
        else if (field == OPM_SEMI)
            decode_mode = MODE_SEMI;
        else if (field == OPM_MANUAL)
            decode_mode = MODE_MANUAL;
        else
            decode_mode = MODE_SHUTDOWN;
    endfunction

    // power a class asks for, in mW; class 0 is budgeted as the full baseline
    function automatic logic [16:0] class_mw(input logic [3:0] cls);
        case (cls)
            4'h1:    class_mw = 17'h00FA0;
            4'h2:    class_mw = 17'h01B58;
            4'h4:    class_mw = 17'h0639C;
            4'h5:    class_mw = 17'h0972C;
            4'h6:    class_mw = 17'h0CDDC;
            4'h7:    class_mw = 17'h11170;
            4'h8:    class_mw = 17'h15F90;
            default: class_mw = BASE_MW;
        endcase
    endfunction
endpackage

// File: hdl/pse_link_if.sv
// link between the host-side controller and the port device
`timescale 1ns/1ps
interface pse_link_if;
    logic [1:0] port_op_mode_field;
    logic       detect_en;
    logic       class_en;
    logic       hp_en;
    logic       extended_power_enable_bit;
    logic       disc_en;
    logic       cmd_detect;
    logic       cmd_class;
    logic       cmd_on;
    logic       cmd_off;
    logic [2:0] det_result;
    logic [3:0] cls_result;
    logic       status_valid;
    logic       power_on;
    logic       startup_fault;
    logic       ilim_event;
    logic       disc_event;
    logic       auto_strap;

    modport device (
        input  port_op_mode_field, detect_en, class_en, hp_en,
               extended_power_enable_bit, disc_en,
               cmd_detect, cmd_class, cmd_on, cmd_off,
        output det_result, cls_result, status_valid, power_on,
               startup_fault, ilim_event, disc_event, auto_strap
    );
    modport host (
        output port_op_mode_field, detect_en, class_en, hp_en,
               extended_power_enable_bit, disc_en,
               cmd_detect, cmd_class, cmd_on, cmd_off,
        input  det_result, cls_result, status_valid, power_on,
               startup_fault, ilim_event, disc_event, auto_strap
    );
endinterface

// File: hdl/pse_host_ctrl.sv
// host-side controller: wishbone registers driving the port link
`timescale 1ns/1ps
module pse_host_ctrl
    import pse_mode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    pse_link_if.host         link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    import pse_mode_pkg::*;

    logic [6:0] ctrl;
    logic       sticky_start;
    logic       sticky_ilim;
    logic       sticky_disc;
    logic       req;
    logic       wr0;
    logic       wr1;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr0 = req && wb_we_i && wb_sel_i[0];
    assign wr1 = req && wb_we_i && wb_sel_i[1];

    always_ff @(posedge clk)
    begin
        if (!nrst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // control fields go out through one register stage; semi/auto detection starts only once enabled, manual detects on command
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ctrl <= CTRL_RESET;
        else if (wr0 && wb_adr_i == REG_CTRL)
            ctrl <= wb_dat_i[6:0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            link.port_op_mode_field        <= OPM_SHUTDOWN;
            link.detect_en                 <= 1'b0;
            link.class_en                  <= 1'b0;
            link.hp_en                     <= 1'b0;
            link.extended_power_enable_bit <= 1'b0;
            link.disc_en                   <= 1'b0;
            link.cmd_detect                <= 1'b0;
            link.cmd_class                 <= 1'b0;
            link.cmd_on                    <= 1'b0;
            link.cmd_off                   <= 1'b0;
        end
        else
        begin
            link.port_op_mode_field        <= ctrl[CTRL_MODE_LSB +: 2];
            link.detect_en                 <= ctrl[CTRL_DET_EN];
            link.class_en                  <= ctrl[CTRL_CLS_EN];
            link.hp_en                     <= ctrl[CTRL_HP_EN];
            link.extended_power_enable_bit <= ctrl[CTRL_EXT_EN];
            link.disc_en                   <= ctrl[CTRL_DISC_EN];
            link.cmd_detect <= wr0 && wb_adr_i == REG_CMD && wb_dat_i[CMD_DETECT];
            link.cmd_class  <= wr0 && wb_adr_i == REG_CMD && wb_dat_i[CMD_CLASS];
            link.cmd_on     <= wr0 && wb_adr_i == REG_CMD && wb_dat_i[CMD_ON];
            link.cmd_off    <= wr0 && wb_adr_i == REG_CMD && wb_dat_i[CMD_OFF];
        end
    end

    // sticky events: a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sticky_start <= 1'b0;
            sticky_ilim  <= 1'b0;
            sticky_disc  <= 1'b0;
        end
        else
        begin
            if (link.startup_fault)
                sticky_start <= 1'b1;
            else if (wr1 && wb_adr_i == REG_STATUS && wb_dat_i[ST_STARTUP])
                sticky_start <= 1'b0;
            if (link.ilim_event)
                sticky_ilim <= 1'b1;
            else if (wr1 && wb_adr_i == REG_STATUS && wb_dat_i[ST_ILIM])
                sticky_ilim <= 1'b0;
            if (link.disc_event)
                sticky_disc <= 1'b1;
            else if (wr1 && wb_adr_i == REG_STATUS && wb_dat_i[ST_DISC])
                sticky_disc <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            wb_dat_o <= 32'h0;
        else if (req && !wb_we_i)
        begin
            if (wb_adr_i == REG_CTRL)
                wb_dat_o <= {25'h0, ctrl};
            else if (wb_adr_i == REG_STATUS)
            begin
                wb_dat_o <= 32'h0;
                wb_dat_o[ST_DET_LSB +: 3] <= link.det_result;
                wb_dat_o[ST_CLS_LSB +: 4] <= link.cls_result;
                wb_dat_o[ST_POWER]        <= link.power_on;
                wb_dat_o[ST_STRAP]        <= link.auto_strap;
                wb_dat_o[ST_STARTUP]      <= sticky_start;
                wb_dat_o[ST_ILIM]         <= sticky_ilim;
                wb_dat_o[ST_DISC]         <= sticky_disc;
            end
            else
                wb_dat_o <= 32'h0;
        end
        else
            wb_dat_o <= 32'h0;
    end
endmodule

// File: sim/pse_port_mode_control_chk.sv
// concurrent checks on the link between host controller and port device
`timescale 1ns/1ps
module pse_port_mode_control_chk (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [1:0] port_op_mode_field,
    input wire logic       detect_en,
    input wire logic       hp_en,
    input wire logic       disc_en,
    input wire logic       cmd_on,
    input wire logic       cmd_off,
    input wire logic [2:0] det_result,
    input wire logic       status_valid,
    input wire logic       power_on,
    input wire logic       startup_fault,
    input wire logic       ilim_event,
    input wire logic       disc_event,
    input wire logic       auto_strap
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // three samples leave room for the gate and its one-cycle echo
    property p_shut; (port_op_mode_field == 2'h0)[*3] |-> !power_on; endproperty
    property p_resv; (port_op_mode_field == 2'h3 && !auto_strap)[*3] |-> !power_on; endproperty
    property p_ilim; ilim_event |-> ##[0:3] !power_on; endproperty
    property p_disc; disc_event && disc_en |-> ##[0:3] !power_on; endproperty
    property p_off; cmd_off |-> ##2 !power_on; endproperty
    property p_on_cmd;
        $rose(power_on) && port_op_mode_field != 2'h3 |-> $past(cmd_on, 2) || $past(cmd_on, 3);
    endproperty
    property p_refuse;
        cmd_on && port_op_mode_field == 2'h2 && hp_en && det_result != 3'h4 && !power_on
            |-> ##[1:2] startup_fault ##[0:3] !power_on;
    endproperty
    property p_det_en; status_valid && port_op_mode_field == 2'h2 |-> detect_en; endproperty
    property p_strap;
        nrst && $past(nrst) && $past(nrst, 2) && $past(nrst, 3) |-> $stable(auto_strap);
    endproperty

    a_shut: assert property (p_shut) else $error("port powered in shutdown");
    a_resv: assert property (p_resv) else $error("port powered in reserved mode");
    a_ilim: assert property (p_ilim) else $error("power kept after current limit");
    a_disc: assert property (p_disc) else $error("power kept after disconnect");
    a_off: assert property (p_off) else $error("power kept after off command");
    a_on_cmd: assert property (p_on_cmd) else $error("power on without command");
    a_refuse: assert property (p_refuse) else $error("bad detect not refused");
    a_det_en: assert property (p_det_en) else $error("detection without enable");
    a_strap: assert property (p_strap) else $error("strap moved after reset");

    c_auto_on: cover property ($rose(power_on) && port_op_mode_field == 2'h3);
    c_refuse: cover property (startup_fault);
    c_manual: cover property (status_valid && port_op_mode_field == 2'h1);
endmodule

// File: sim/pse_port_mode_control_tb.sv
// self-checking bench: host controller and port device joined by the link
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module pse_port_mode_control_tb;
    import pse_mode_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [3:0]  wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_rdat, rdat;
    logic        strap_auto = 1'b0, detect_done = 1'b0, class_done = 1'b0;
    logic        ilim_fault = 1'b0, disconnect = 1'b0;
    logic [2:0]  detect_code = 3'h0;
    logic [3:0]  class_code = 4'h0, icut_sel;
    logic        detect_start, class_start, class_ext, gate_on, ilim_high;
    logic [16:0] budget_mw;
    int          failures = 0, tests_run = 0, n;

    always #2.5 clk = ~clk;
    pse_link_if link ();
    pse_host_ctrl pse_host_ctrl_i (.clk(clk), .nrst(nrst), .link(link), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    // short waits keep the run brief; a low variant limit lets class 6 be refused
    pse_port_device #(.WAIT_CYC(20), .WAIT_MID_CYC(40), .VARIANT_MW(38700)) pse_port_device_i (
        .clk(clk), .nrst(nrst), .link(link), .strap_auto(strap_auto), .strap_mid(1'b0),
        .detect_done(detect_done), .detect_code(detect_code), .class_done(class_done),
        .class_code(class_code), .ilim_fault(ilim_fault), .disconnect(disconnect),
        .detect_start(detect_start), .class_start(class_start), .class_ext(class_ext),
        .gate_on(gate_on), .icut_sel(icut_sel), .ilim_high(ilim_high), .budget_mw(budget_mw));
    pse_port_mode_control_chk chk_i (.clk(clk), .nrst(nrst),
        .port_op_mode_field(link.port_op_mode_field), .detect_en(link.detect_en),
        .hp_en(link.hp_en), .disc_en(link.disc_en), .cmd_on(link.cmd_on), .cmd_off(link.cmd_off),
        .det_result(link.det_result), .status_valid(link.status_valid),
        .power_on(link.power_on), .startup_fault(link.startup_fault),
        .ilim_event(link.ilim_event), .disc_event(link.disc_event), .auto_strap(link.auto_strap));

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic bound(input logic ok);
        if (!ok)
        begin
            $display("[ERR] %0t wait ran out", $time);
            failures++;
            end_of_test();
        end
    endtask

    // samples at the edge, so values are those the design registered
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (wb_ack !== 1'b1 && k < 20);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        bound(wb_ack === 1'b1);
    endtask

    task automatic cmd(input int b);
        wb(1'b1, REG_CMD, 32'h1 << b);
    endtask

    task automatic wait_val(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (s !== v && k < lim);
        bound(s === v);
    endtask

    // stands in for the measurement front end: one done pulse per start
    task automatic answer(input logic cls);
        if (cls)
            wait_val(class_start, 1'b1, 200);
        else
            wait_val(detect_start, 1'b1, 200);
        class_done <= cls;
        detect_done <= !cls;
        @(posedge clk);
        class_done <= 1'b0;
        detect_done <= 1'b0;
    endtask

    task automatic quiet(ref logic s, input int k);
        repeat (k)
        begin
            @(posedge clk);
            `CHK(s, 1'b0)
        end
    endtask

    task automatic do_reset(input logic sa);
        nrst <= 1'b0;
        strap_auto <= sa;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    task automatic t_shutdown();
        wb(1'b0, REG_BUDGET, 32'h0);
        `CHK(rdat, 32'h0)
        `CHK(budget_mw, 17'h032C8)
        wb(1'b1, REG_CTRL, 32'h04);
        cmd(CMD_ON);
        quiet(detect_start, 30);
        `CHK(gate_on, 1'b0)
        strap_auto <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h07);
        cmd(CMD_ON);
        quiet(gate_on, 10);
        $display("shutdown and reserved done");
    endtask

    task automatic t_manual();
        detect_code <= 3'h4;
        class_code <= 4'h2;
        wb(1'b1, REG_CTRL, 32'h01);
        cmd(CMD_DETECT);
        answer(1'b0);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rdat[2:0], 3'h4)
        quiet(detect_start, 30);
        cmd(CMD_CLASS);
        answer(1'b1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rdat[7:4], 4'h2)
        cmd(CMD_ON);
        wait_val(gate_on, 1'b1, 10);
        cmd(CMD_OFF);
        wait_val(gate_on, 1'b0, 10);
        $display("manual done");
    endtask

    task automatic t_semi();
        detect_code <= 3'h0;
        class_code <= 4'h4;
        wb(1'b1, REG_CTRL, 32'h02);
        quiet(detect_start, 40);
        wb(1'b1, REG_CTRL, 32'h1E);
        answer(1'b0);
        cmd(CMD_ON);
        repeat (4) @(posedge clk);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rdat[ST_STARTUP], 1'b1)
        `CHK(gate_on, 1'b0)
        detect_code <= 3'h4;
        answer(1'b0);
        answer(1'b1);
        `CHK(class_ext, 1'b0)
        n = 0;
        while (detect_start !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= 20 && n < 200, 1'b1)
        `CHK(gate_on, 1'b0)
        `CHK(icut_sel, 4'h0)
        `CHK(budget_mw, 17'h0639C)
        cmd(CMD_ON);
        wait_val(gate_on, 1'b1, 10);
        ilim_fault <= 1'b1;
        @(posedge clk);
        ilim_fault <= 1'b0;
        wait_val(gate_on, 1'b0, 5);
        $display("semi-automatic done");
    endtask

    task automatic t_auto();
        do_reset(1'b1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(rdat[ST_STRAP], 1'b1)
        wb(1'b1, REG_CTRL, 32'h7F);
        answer(1'b0);
        answer(1'b1);
        `CHK(class_ext, 1'b1)
        wait_val(gate_on, 1'b1, 10);
        `CHK(icut_sel, 4'h4)
        `CHK(ilim_high, 1'b1)
        disconnect <= 1'b1;
        @(posedge clk);
        disconnect <= 1'b0;
        wait_val(gate_on, 1'b0, 5);
        class_code <= 4'h6;
        answer(1'b0);
        answer(1'b1);
        quiet(gate_on, 20);
        $display("automatic done");
    endtask

    initial
    begin
        do_reset(1'b0);
        t_shutdown();
        t_manual();
        t_semi();
        t_auto();
        end_of_test();
    end
endmodule
